/* File: pkg/rrfwd_pkg.sv */
// Shared constants for the radio repeater forwarding block
package rrfwd_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] RRFWD_CTRL_OFS = 8'h00;
  localparam logic [7:0] RRFWD_ADDR_OFS = 8'h04;
  localparam logic [7:0] RRFWD_NETWORK_IDENTIFIER_OFS = 8'h08;
  localparam logic [7:0] RRFWD_STAT_OFS = 8'h0c;
  localparam logic [7:0] RRFWD_CNT_OFS = 8'h10;
  localparam logic [7:0] RRFWD_PARAM0_OFS = 8'h14;
  localparam logic [7:0] RRFWD_PARAM1_OFS = 8'h18;

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int RRFWD_CTRL_MODE_LSB = 0;
  localparam int RRFWD_CTRL_RPT_BIT = 2;
  localparam int RRFWD_CTRL_FIXED_BIT = 3;
  localparam int RRFWD_CTRL_RELOAD_BIT = 4;
  localparam int RRFWD_CTRL_DEFAULT_BIT = 5;

  // ----------------------------------------
  // Factory defaults: bytes 62 00 00 00 00 00
  // ----------------------------------------
  localparam logic [7:0] RRFWD_DEF_B0 = 8'h62;
  localparam logic [7:0] RRFWD_DEF_BX = 8'h00;
  localparam logic [7:0] RRFWD_DEF_CHANNEL = 8'h32;
  localparam logic [15:0] RRFWD_DEF_ADDR = 16'h0000;
  localparam logic [7:0] RRFWD_DEF_NETWORK_IDENTIFIER = 8'h00;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int RRFWD_CLK_HZ = 25000000;
  localparam int RRFWD_RELOAD_US = 100;
  localparam int RRFWD_RELOAD_CYC = (RRFWD_CLK_HZ / 1000000) * RRFWD_RELOAD_US;

  typedef enum logic [1:0] {
    RRFWD_MODE_NORMAL = 2'b00,
    RRFWD_MODE_WOR = 2'b01,
    RRFWD_MODE_CONFIG = 2'b10,
    RRFWD_MODE_SLEEP = 2'b11
  } rrfwd_mode_t;

  typedef enum logic [1:0] {
    RRFWD_ST_RELOAD = 2'b00,
    RRFWD_ST_IDLE = 2'b01,
    RRFWD_ST_RPT = 2'b10
  } rrfwd_state_t;

endpackage

/* File: tb/rrfwd_bench.sv */
// Self-checking bench for the repeater forwarding block
`timescale 1ns/1ps
`default_nettype none
module rrfwd_bench;
  import rrfwd_pkg::*;
  logic aclk = '0;
  logic aresetn = '0;
  logic [7:0] s_axi_awaddr = '0;
  logic [7:0] s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0;
  logic [31:0] s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic s_axi_arvalid = '0, s_axi_rready = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic rx_valid = '0, rx_repeated = '0, host_tx_valid = '1, slow = '0;
  logic [7:0] rx_data = '0, rx_network_identifier = '0;
  logic [15:0] rx_target = '0, rx_source = '0;
  logic rx_ready, tx_valid, tx_ready, host_valid, host_ready;
  logic host_tx_ready, status_ok, lowpower_en;
  logic [7:0] tx_data, tx_network_identifier, host_data, n_tx, n_host, last_host, n0;
  logic [15:0] last_tx;
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  int k;
  logic [7:0] r_net [4] = '{8'h08, 8'h33, 8'h55, 8'h07};
  logic [7:0] r_dat [4] = '{8'ha5, 8'h3c, 8'h11, 8'h22};
  logic [7:0] r_to [4] = '{8'h33, 8'h08, 8'h00, 8'h00};
  logic [3:0] r_fw = 4'h3;

  rrfwd_top #(.RELOAD_CYC(4)) i_rrfwd_top (.*);
  rrfwd_peer i_rrfwd_peer (.*);

  initial
  begin
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = '0;
    wd = '0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= '1;
    s_axi_wvalid <= '1;
    s_axi_bready <= '1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (s_axi_awready)
        ad = '1;
      if (s_axi_wready)
        wd = '1;
      if (ad)
        s_axi_awvalid <= '0;
      if (wd)
        s_axi_wvalid <= '0;
    end
    while (!s_axi_bvalid)
      @(posedge aclk);
    s_axi_bready <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= '1;
    s_axi_rready <= '1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= '0;
    end
    while (!s_axi_rvalid);
    s_axi_rready <= '0;
    chk("rresp", s_axi_rresp, er);
    if (er == 2'h0)
      chk("rdata", s_axi_rdata, e);
  endtask

  // Valid stays up between words so bursts run back to back
  task automatic snd(input logic [7:0] n, d, input logic [15:0] t, s);
    if (!rx_valid)
      @(posedge aclk);
    rx_valid <= '1;
    rx_network_identifier <= n;
    rx_data <= d;
    rx_target <= t;
    rx_source <= s;
    do
      @(posedge aclk);
    while (!rx_ready);
  endtask

  // Released data and network lines show the inverse, not a stale copy
  task automatic rx_idle();
    rx_valid <= '0;
    rx_data <= ~rx_data;
    rx_network_identifier <= ~rx_network_identifier;
  endtask

  initial
  begin
    repeat (12) @(posedge aclk);
    chk("rst_status", status_ok, 0);
    chk("rst_tx", tx_valid, 0);
    aresetn <= '1;
    k = 0;
    while (!status_ok)
    begin
      @(posedge aclk);
      k++;
    end
    chk("reload_len", k > 4, 1);
    rd(RRFWD_PARAM0_OFS, 32'h62, 2'h0);
    rd(RRFWD_NETWORK_IDENTIFIER_OFS, 32'h3200, 2'h0);
    rd(RRFWD_ADDR_OFS, 32'h0, 2'h0);
    rd(8'h1c, 32'h0, 2'h2);
    wr(RRFWD_CTRL_OFS, 32'h6);
    wr(RRFWD_ADDR_OFS, 32'h0833);
    wr(RRFWD_NETWORK_IDENTIFIER_OFS, 32'h3255);
    wr(RRFWD_CTRL_OFS, 32'h4);
    // Repeat state is entered one edge after the mode write lands
    @(posedge aclk);
    chk("host_blocked", host_tx_ready, 0);
    rd(RRFWD_STAT_OFS, 32'h6, 2'h0);
    for (int i = 0; i < 4; i++)
    begin
      n0 = n_tx;
      k = n_host;
      snd(r_net[i], r_dat[i], 16'h0, 16'h0);
      rx_idle();
      repeat (6) @(posedge aclk);
      chk("fwd_n", n_tx - n0, r_fw[i]);
      if (r_fw[i])
        chk("fwd_w", last_tx, {r_to[i], r_dat[i]});
      chk("host_n", n_host, k);
    end
    slow <= '1;
    n0 = n_tx;
    for (int j = 1; j < 5; j++)
      snd(8'h08, 8'(j), 16'h0, 16'h0);
    rx_idle();
    repeat (14) @(posedge aclk);
    chk("burst_n", n_tx - n0, 4);
    chk("burst_last", last_tx, 16'h3304);
    wr(RRFWD_CTRL_OFS, 32'h7);
    @(posedge aclk);
    chk("lp_rpt", lowpower_en, 0);
    wr(RRFWD_CTRL_OFS, 32'h2);
    wr(RRFWD_CTRL_OFS, 32'h3);
    @(posedge aclk);
    chk("lp_sleep", lowpower_en, 1);
    wr(RRFWD_CTRL_OFS, 32'h2);
    k = 0;
    while (status_ok && k < 8)
    begin
      @(posedge aclk);
      k++;
    end
    chk("wake_low", status_ok, 0);
    while (!status_ok)
      @(posedge aclk);
    wr(RRFWD_CTRL_OFS, 32'ha);
    wr(RRFWD_ADDR_OFS, 32'h0833);
    wr(RRFWD_NETWORK_IDENTIFIER_OFS, 32'h3255);
    wr(RRFWD_CTRL_OFS, 32'h8);
    k = n_host;
    snd(8'h55, 8'h5a, 16'h0833, 16'h0833);
    rx_idle();
    repeat (8) @(posedge aclk);
    chk("host_n", n_host - 8'(k), 1);
    chk("host_w", last_host, 8'h5a);
    snd(8'h55, 8'h6b, 16'h0833, 16'h0834);
    rx_idle();
    repeat (8) @(posedge aclk);
    chk("host_drop", n_host - 8'(k), 1);
    wr(RRFWD_CTRL_OFS, 32'h2);
    // Repeat bit set outside normal mode: single resend path
    wr(RRFWD_CTRL_OFS, 32'h5);
    n0 = n_tx;
    snd(8'h55, 8'h77, 16'h1234, 16'h0000);
    rx_idle();
    repeat (8) @(posedge aclk);
    chk("once_n", n_tx - n0, 1);
    chk("once_w", last_tx, 16'h5577);
    wr(RRFWD_CTRL_OFS, 32'h22);
    rd(RRFWD_ADDR_OFS, 32'h0, 2'h0);
    rd(RRFWD_PARAM0_OFS, 32'h62, 2'h0);
    wrap_up();
  end
endmodule // rrfwd_bench
`default_nettype wire

/* File: tb/rrfwd_checker.sv */
// Port checker for the repeater forwarding block
`timescale 1ns/1ps
`default_nettype none
module rrfwd_checker
#(
  parameter int DW = 8
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awready, // Aw ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic tx_valid, // Fwd valid
  input wire logic tx_ready, // Fwd ready
  input wire logic [DW-1:0] tx_data, // Fwd word
  input wire logic [7:0] tx_network_identifier, // Fwd net
  input wire logic host_valid, // Host valid
  input wire logic host_ready, // Host ready
  input wire logic [DW-1:0] host_data, // Host word
  input wire logic host_tx_ready, // Host send ready
  input wire logic status_ok, // Status
  input wire logic lowpower_en // Low power
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Bench sets the reload length to 4
  property p_rst_reload;
    $rose(aresetn) |-> !status_ok [*4] ##[1:3] status_ok;
  endproperty
  a_rst_reload: assert property (p_rst_reload)
    else $error("status high too early after reset");
  property p_rst_quiet;
    $rose(aresetn) |-> !tx_valid && !host_valid && !status_ok;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active out of reset");
  property p_rpt_nolp;
    (!host_tx_ready && status_ok) [*3] |-> !lowpower_en;
  endproperty
  a_rpt_nolp: assert property (p_rpt_nolp)
    else $error("low power while repeating");
  property p_tx_hold;
    tx_valid && !tx_ready |=>
      tx_valid && $stable(tx_data) && $stable(tx_network_identifier);
  endproperty
  a_tx_hold: assert property (p_tx_hold)
    else $error("forward word changed while stalled");
  property p_host_hold;
    host_valid && !host_ready |=> host_valid && $stable(host_data);
  endproperty
  a_host_hold: assert property (p_host_hold)
    else $error("host word changed while stalled");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready;
  endproperty
  a_aw_block: assert property (p_aw_block)
    else $error("write taken while answer pending");
  property p_b_once;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
  endproperty
  a_b_once: assert property (p_b_once)
    else $error("write answered twice");
  property p_r_once;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
  endproperty
  a_r_once: assert property (p_r_once)
    else $error("read answered twice");

  c_fwd: cover property (tx_valid && tx_ready);
  c_host: cover property (host_valid && host_ready);
  c_lp: cover property (lowpower_en);
endmodule // rrfwd_checker

bind rrfwd_top rrfwd_checker #(.DW(DW)) i_rrfwd_checker (.*);
`default_nettype wire

/* File: tb/rrfwd_peer.sv */
// Far-side model: peer nodes and host taking words
`timescale 1ns/1ps
`default_nettype none
module rrfwd_peer
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic slow, // Stall every other cycle
  input wire logic tx_valid, // Fwd valid
  output logic tx_ready, // Fwd ready
  input wire logic [7:0] tx_data, // Fwd word
  input wire logic [7:0] tx_network_identifier, // Fwd net
  input wire logic host_valid, // Host valid
  output logic host_ready, // Host ready
  input wire logic [7:0] host_data, // Host word
  output logic [7:0] n_tx, // Words forwarded
  output logic [15:0] last_tx, // Last net and word
  output logic [7:0] n_host, // Words delivered
  output logic [7:0] last_host // Last host word
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_ready <= '0;
      host_ready <= '0;
      n_tx <= '0;
      n_host <= '0;
    end
    else
    begin
      tx_ready <= slow ? ~tx_ready : '1;
      host_ready <= slow ? ~host_ready : '1;
      if (tx_valid && tx_ready)
      begin
        n_tx <= n_tx + 8'h01;
        last_tx <= {tx_network_identifier, tx_data};
      end
      if (host_valid && host_ready)
      begin
        n_host <= n_host + 8'h01;
        last_host <= host_data;
      end
    end
  end
endmodule // rrfwd_peer
`default_nettype wire

/* File: verilog/rrfwd_skid.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rrfwd_skid
#(
  parameter int WIDTH = 8
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic s_valid, // Fill side valid
  output logic s_ready, // Fill side ready
  input wire logic [WIDTH-1:0] s_data, // Fill side data
  output logic m_valid, // Drain side valid
  input wire logic m_ready, // Drain side ready
  output logic [WIDTH-1:0] m_data // Drain side data
);

  initial
  begin
    if (WIDTH < 1) $error("rrfwd_skid: WIDTH must be positive");
  end

  logic [WIDTH-1:0] mem_r [0:1];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;

  wire push = s_valid && s_ready;
  wire pop = m_valid && m_ready;

  assign s_ready = (cnt_r != 2'd2);
  assign m_valid = (cnt_r != 2'd0);
  assign m_data = mem_r[rp_r];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'd0;
    end
    else
    begin
      if (push)
        wp_r <= ~wp_r;
      if (pop)
        rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
      mem_r[wp_r] <= s_data;
  end

endmodule // rrfwd_skid
`default_nettype wire

/* File: verilog/rrfwd_top.sv */
// Repeater forwarding logic with AXI4-Lite control registers
// Operation
// - Repeating starts only after repeater configured, then normal mode entered.
// - In repeater mode the address bytes are paired network identifiers.
// - In repeater mode, own network identifier is ignored when deciding what to forward.
// - Repeater mode blocks host data both ways and any low-power state.
// - Leaving sleep mode or reset reloads parameters; status held low.
// - Forwarding is symmetric between the two paired networks.
// - Factory defaults read 62 00 00 00 00 00, channel 0x32.
// - Forwarded data reaches host only when addresses match in fixed mode, else dropped; without fixed, any address reaches host.
// - With repeat enabled, packets for other targets are resent once.
//
// Register access over AXI4-Lite and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module rrfwd_top
  import rrfwd_pkg::*;
#(
  parameter int DW = 8, // Payload width
  parameter int RELOAD_CYC = RRFWD_RELOAD_CYC // Reload duration
)
(
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rx_valid, // Received packet word valid
  output logic rx_ready, // Received packet word ready
  input wire logic [DW-1:0] rx_data, // Received payload word
  input wire logic [7:0] rx_network_identifier, // Source network of packet
  input wire logic [15:0] rx_target, // Target node address
  input wire logic [15:0] rx_source, // Originating node address
  input wire logic rx_repeated, // Packet came via a repeater
  output logic tx_valid, // Retransmit word valid
  input wire logic tx_ready, // Retransmit accepted
  output logic [DW-1:0] tx_data, // Retransmit payload
  output logic [7:0] tx_network_identifier, // Destination network
  output logic host_valid, // Delivery to host valid
  input wire logic host_ready, // Host accepts
  output logic [DW-1:0] host_data, // Delivered payload
  input wire logic host_tx_valid, // Host offers data to send
  output logic host_tx_ready, // Host data accepted
  output logic status_ok, // Status indicator, low on reload
  output logic lowpower_en // Low-power permission
);

  initial
  begin
    if (DW < 1) $error("rrfwd_top: DW must be positive");
    if (RELOAD_CYC < 1) $error("rrfwd_top: RELOAD_CYC must be >= 1");
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [1:0] mode_r;
  logic rpt_cfg_r;
  logic fixed_r;
  logic [15:0] addr_r;
  logic [7:0] network_identifier_r;
  logic [7:0] chan_r;
  logic [31:0] fwd_cnt_r;
  logic [31:0] drop_cnt_r;
  rrfwd_state_t st_r;
  logic [31:0] rl_cnt_r;
  logic rl_req_r;
  logic status_r;
  logic lp_r;

  // ----------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;

  wire aw_take = s_axi_awvalid && !aw_hold_r && !bvalid_r;
  wire w_take = s_axi_wvalid && !w_hold_r && !bvalid_r;
  wire aw_have = aw_hold_r || aw_take;
  wire w_have = w_hold_r || w_take;
  wire wr_go = aw_have && w_have && !bvalid_r;
  wire [7:0] wa = aw_hold_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_hold_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_hold_r ? wstrb_r : s_axi_wstrb;
  wire wr_ctrl = wr_go && (wa == RRFWD_CTRL_OFS);
  wire wr_addr = wr_go && (wa == RRFWD_ADDR_OFS);
  wire wr_network_identifier = wr_go && (wa == RRFWD_NETWORK_IDENTIFIER_OFS);
  wire wr_ok = wr_ctrl || wr_addr || wr_network_identifier
    || (wa == RRFWD_STAT_OFS) || (wa == RRFWD_CNT_OFS)
    || (wa == RRFWD_PARAM0_OFS) || (wa == RRFWD_PARAM1_OFS);
  wire [1:0] new_mode = wd[RRFWD_CTRL_MODE_LSB +: 2];
  wire set_default = wr_ctrl && ws[0] && wd[RRFWD_CTRL_DEFAULT_BIT];
  wire soft_reload = wr_ctrl && ws[0] && wd[RRFWD_CTRL_RELOAD_BIT];
  wire leave_sleep = wr_ctrl && ws[0] && (mode_r == RRFWD_MODE_SLEEP)
    && (new_mode != RRFWD_MODE_SLEEP);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'b00;
    end
    else
    begin
      if (aw_take)
        awaddr_r <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_hold_r <= aw_have && !wr_go;
      w_hold_r <= w_have && !wr_go;
      if (wr_go)
      begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        bvalid_r <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode_r <= RRFWD_MODE_CONFIG;
      rpt_cfg_r <= 1'b0;
      fixed_r <= 1'b0;
      addr_r <= RRFWD_DEF_ADDR;
      network_identifier_r <= RRFWD_DEF_NETWORK_IDENTIFIER;
      chan_r <= RRFWD_DEF_CHANNEL;
    end
    else if (set_default)
    begin
      rpt_cfg_r <= 1'b0;
      fixed_r <= 1'b0;
      addr_r <= RRFWD_DEF_ADDR;
      network_identifier_r <= RRFWD_DEF_NETWORK_IDENTIFIER;
      chan_r <= RRFWD_DEF_CHANNEL;
    end
    else
    begin
      if (wr_ctrl && ws[0])
      begin
        if (!(st_r == RRFWD_ST_RPT && new_mode == RRFWD_MODE_SLEEP))
          mode_r <= new_mode;
        if (mode_r == RRFWD_MODE_CONFIG)
        begin
          rpt_cfg_r <= wd[RRFWD_CTRL_RPT_BIT];
          fixed_r <= wd[RRFWD_CTRL_FIXED_BIT];
        end
      end
      if (wr_addr && mode_r == RRFWD_MODE_CONFIG)
      begin
        if (ws[0]) addr_r[7:0] <= wd[7:0];
        if (ws[1]) addr_r[15:8] <= wd[15:8];
      end
      if (wr_network_identifier && mode_r == RRFWD_MODE_CONFIG)
      begin
        if (ws[0]) network_identifier_r <= wd[7:0];
        if (ws[1]) chan_r <= wd[15:8];
      end
    end
  end

  // ----------------------------------------
  // Reload and operating state
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r <= RRFWD_ST_RELOAD;
      rl_cnt_r <= 32'd0;
      status_r <= 1'b0;
      rl_req_r <= 1'b0;
      lp_r <= 1'b0;
    end
    else
    begin
      rl_req_r <= leave_sleep || soft_reload;
      lp_r <= (mode_r == RRFWD_MODE_SLEEP) && (st_r != RRFWD_ST_RPT);
      case (st_r)
        RRFWD_ST_RELOAD:
        begin
          status_r <= 1'b0;
          if (rl_cnt_r == 32'(RELOAD_CYC - 1))
          begin
            rl_cnt_r <= 32'd0;
            st_r <= RRFWD_ST_IDLE;
          end
          else
            rl_cnt_r <= rl_cnt_r + 32'd1;
        end
        RRFWD_ST_IDLE:
        begin
          status_r <= 1'b1;
          if (rl_req_r)
          begin
            status_r <= 1'b0;
            st_r <= RRFWD_ST_RELOAD;
          end
          else if (rpt_cfg_r && mode_r == RRFWD_MODE_NORMAL)
            st_r <= RRFWD_ST_RPT;
        end
        RRFWD_ST_RPT:
        begin
          status_r <= 1'b1;
          if (rl_req_r)
          begin
            status_r <= 1'b0;
            st_r <= RRFWD_ST_RELOAD;
          end
          else if (!rpt_cfg_r || mode_r != RRFWD_MODE_NORMAL)
            st_r <= RRFWD_ST_IDLE;
        end
        default: st_r <= RRFWD_ST_RELOAD;
      endcase
    end
  end

  // ----------------------------------------
  // Forwarding decision
  // ----------------------------------------
  wire rpt_on = (st_r == RRFWD_ST_RPT);
  wire [7:0] net_a = addr_r[15:8];
  wire [7:0] net_b = addr_r[7:0];
  wire from_a = (rx_network_identifier == net_a);
  wire from_b = (rx_network_identifier == net_b);
  wire [7:0] dest_net = from_a ? net_b : net_a;
  wire rpt_fwd = rpt_on && (from_a || from_b);
  // forward once when not for us
  wire once_fwd = !rpt_on && rpt_cfg_r && (st_r == RRFWD_ST_IDLE)
    && (rx_network_identifier == network_identifier_r) && (rx_target != addr_r) && !rx_repeated;
  // host delivery on address match when fixed, any address otherwise
  wire to_host = !rpt_on && (st_r == RRFWD_ST_IDLE)
    && (rx_network_identifier == network_identifier_r) && (rx_source == addr_r || !fixed_r)
    && (!fixed_r || rx_target == addr_r);
  wire fwd_sel = rpt_fwd || once_fwd;
  wire [7:0] fwd_net = rpt_on ? dest_net : network_identifier_r;

  logic buf_ready;
  logic hbuf_ready;
  wire buf_in_v = rx_valid && fwd_sel && hbuf_ready;
  wire hbuf_in_v = rx_valid && to_host && buf_ready;
  assign rx_ready = buf_ready && hbuf_ready;

  rrfwd_skid #(.WIDTH(DW + 8)) u_fwd_buf
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_valid(buf_in_v),
    .s_ready(buf_ready),
    .s_data({fwd_net, rx_data}),
    .m_valid(tx_valid),
    .m_ready(tx_ready),
    .m_data({tx_network_identifier, tx_data})
  );

  rrfwd_skid #(.WIDTH(DW)) u_host_buf
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_valid(hbuf_in_v),
    .s_ready(hbuf_ready),
    .s_data(rx_data),
    .m_valid(host_valid),
    .m_ready(host_ready),
    .m_data(host_data)
  );

  assign host_tx_ready = (st_r == RRFWD_ST_IDLE);
  assign status_ok = status_r;
  assign lowpower_en = lp_r;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fwd_cnt_r <= 32'd0;
      drop_cnt_r <= 32'd0;
    end
    else if (rx_valid && rx_ready)
    begin
      if (fwd_sel)
        fwd_cnt_r <= fwd_cnt_r + 32'd1;
      else if (!to_host)
        drop_cnt_r <= drop_cnt_r + 32'd1;
    end
  end

  // ----------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  wire ar_take = s_axi_arvalid && !rvalid_r;
  wire [31:0] ctrl_rd = {26'd0, 1'b0, 1'b0, fixed_r, rpt_cfg_r, mode_r};
  wire [31:0] stat_rd = {28'd0, lp_r, status_r, st_r};
  wire [31:0] p0_rd = {RRFWD_DEF_BX, RRFWD_DEF_BX, RRFWD_DEF_BX,
    (rpt_cfg_r ? RRFWD_DEF_B0 : RRFWD_DEF_B0)};
  wire [31:0] rd_mux =
    (s_axi_araddr == RRFWD_CTRL_OFS) ? ctrl_rd :
    (s_axi_araddr == RRFWD_ADDR_OFS) ? {16'd0, addr_r} :
    (s_axi_araddr == RRFWD_NETWORK_IDENTIFIER_OFS) ? {16'd0, chan_r, network_identifier_r} :
    (s_axi_araddr == RRFWD_STAT_OFS) ? stat_rd :
    (s_axi_araddr == RRFWD_CNT_OFS) ? fwd_cnt_r :
    (s_axi_araddr == RRFWD_PARAM0_OFS) ? p0_rd :
    (s_axi_araddr == RRFWD_PARAM1_OFS) ? drop_cnt_r : 32'h0000_0000;
  wire rd_ok = (s_axi_araddr <= RRFWD_PARAM1_OFS)
    && (s_axi_araddr[1:0] == 2'b00);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= 2'b00;
    end
    else if (ar_take)
    begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_ok ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      rvalid_r <= 1'b0;
  end

  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

endmodule // rrfwd_top
`default_nettype wire
